/* File: hdl/rivm_map.vh */
`ifndef RIVM_MAP_VH
`define RIVM_MAP_VH

// Register byte offsets
`define RIVM_OFS_GIC        8'h00
`define RIVM_OFS_MASK       8'h04
`define RIVM_OFS_PEND       8'h08
`define RIVM_OFS_STATUS     8'h0C
`define RIVM_OFS_RESET      8'h10
`define RIVM_OFS_LOOKUP     8'h14
`define RIVM_OFS_TAKEN      8'h18

// Control register fields
`define RIVM_GIC_CHG_BIT    0
`define RIVM_GIC_SEL_BIT    1

// Status register fields
`define RIVM_ST_WIN_BIT     0
`define RIVM_ST_BLOCK_BIT   1
`define RIVM_ST_VALID_BIT   2
`define RIVM_ST_SEL_BIT     3
`define RIVM_ST_NUM_LSB     8
`define RIVM_ST_FUSE_BIT    16

// Lookup register fields
`define RIVM_LK_NUM_LSB     20

// Reset values
`define RIVM_RST_MASK       20'h00000
`define RIVM_RST_SEL        1'b0

// Vector layout
`define RIVM_RESET_ADDR     14'h0000
`define RIVM_VEC_BASE       14'h0002
`define RIVM_VEC_FIRST      5'h02
`define RIVM_VEC_LAST       5'h15
`define RIVM_RESET_VEC      5'h01

// Timing
`define RIVM_CHG_WINDOW     3'h4

// Bus answers
`define RIVM_RESP_OKAY      2'h0
`define RIVM_RESP_SLVERR    2'h2

`endif

/* File: hdl/rivm_prio_enc.v */
`timescale 1ns/1ps
`include "rivm_map.vh"

module rivm_prio_enc #(
  parameter NSRC = 20
) (
  // Requests
  input  wire [NSRC-1:0] pend,
  // Winner
  output reg             any,
  output reg  [4:0]      idx,
  output reg  [NSRC-1:0] onehot
);

  integer i;

  // Lowest index wins
  always @*
  begin
    any    = 1'b0;
    idx    = 5'h00;
    onehot = {NSRC{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
      if (pend[i])
      begin
        any    = 1'b1;
        idx    = i[4:0];
        onehot = {{(NSRC-1){1'b0}}, 1'b1} << i;
      end
    end
  end

endmodule // rivm_prio_enc

/* File: hdl/rivm_change_guard.v */
`timescale 1ns/1ps
`include "rivm_map.vh"

module rivm_change_guard (
  // Clock and reset
  input  wire clk,
  input  wire nrst,
  // Control events
  input  wire chg_start,
  input  wire sel_write,
  input  wire instr_retire,
  // State
  output wire window_open,
  output wire irq_block
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OPEN = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [2:0] state_r;
  reg [2:0] cnt_r;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 3'h0;
    end
    else if (chg_start)
    begin
      state_r <= ST_OPEN;
      cnt_r   <= 3'h1;
    end
    else
    begin
      case (state_r)
        ST_OPEN:
        begin
          if (sel_write)
            state_r <= ST_WAIT;
          else if (cnt_r == `RIVM_CHG_WINDOW)
            state_r <= ST_IDLE;
          cnt_r <= cnt_r + 3'h1;
        end
        ST_WAIT:
        begin
          if (instr_retire)
            state_r <= ST_IDLE;
        end
        ST_IDLE:
          cnt_r <= 3'h0;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Window open for select write
  assign window_open = (state_r == ST_OPEN);
  // Requests held off, global enable untouched
  assign irq_block   = (state_r != ST_IDLE);

endmodule // rivm_change_guard

/* File: hdl/rivm_vector_map.v */
`timescale 1ns/1ps
`include "rivm_map.vh"

// Behaviour
// - All resets start at word address zero unless boot fuse relocates it.
// - External requests 0, 1, 2 vector to 0x002, 0x004, 0x006.
// - Timer 2 compare at 0x008, overflow at 0x00A.
// - Timer 1 capture 0x00C, compare A 0x00E, compare B 0x010, overflow 0x012.
// - Timer 0 compare at 0x014, overflow at 0x016.
// - Serial done 0x018, rx 0x01A, tx empty 0x01C, tx done 0x01E.
// - Converter done 0x020, EEPROM ready 0x022, comparator 0x024.
// - Two-wire 0x026, program store ready 0x028, twenty-one vectors total.
// - Programmed boot fuse (0) starts execution at boot reset address.
// - Select bit set adds boot section start to each interrupt vector address.
// - Vector table starts at 0x0002 or boot address plus 0x0002.
// - Vector fetch happens only when an enabled interrupt is taken.
// - Change enable blocks interrupts until after next instruction or four cycles.
// - Select bit is bit 1, change enable bit 0 of control register.
module rivm_vector_map #(
  parameter ADDR_W = 14,
  parameter NSRC   = 20,
  parameter AXI_AW = 8
) (
  // Clock and reset
  input  wire              clk,
  input  wire              nrst,
  // Fuses and boot section
  input  wire              boot_reset_fuse,
  input  wire [ADDR_W-1:0] boot_start_addr,
  // Peripheral requests
  input  wire [NSRC-1:0]   irq_req,
  output wire [NSRC-1:0]   irq_taken,
  // CPU fetch side
  input  wire              global_irq_enable,
  input  wire              instr_retire,
  input  wire              irq_ack,
  output wire              irq_valid,
  output wire [ADDR_W-1:0] irq_vector_addr,
  output wire [4:0]        irq_vector_num,
  output wire [ADDR_W-1:0] reset_fetch_addr,
  output wire              reset_fetch,
  // AXI4-Lite write address
  input  wire [AXI_AW-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [AXI_AW-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam [ADDR_W-1:0] RESET_ADDR = `RIVM_RESET_ADDR;
  localparam [ADDR_W-1:0] VEC_BASE   = `RIVM_VEC_BASE;

  // Vector address of source index
  function [ADDR_W-1:0] vec_addr;
    input [4:0]        idx;
    input              sel;
    input [ADDR_W-1:0] boot;
    reg   [ADDR_W-1:0] base;
    begin
      base     = VEC_BASE + {{(ADDR_W-6){1'b0}}, idx, 1'b0};
      vec_addr = sel ? base + boot : base;
    end
  endfunction

  // Word select of bus address
  function [AXI_AW-1:0] word_of;
    input [AXI_AW-1:0] a;
    begin
      word_of = {a[AXI_AW-1:2], 2'b00};
    end
  endfunction

  // Control and configuration state
  reg              sel_r;
  reg [NSRC-1:0]   mask_r;
  reg [4:0]        lookup_r;
  reg [15:0]       taken_cnt_r;
  reg [ADDR_W-1:0] reset_addr_r;
  reg              reset_fetch_r;
  reg              boot_seen_r;

  // Arbitration result
  reg              pend_any_r;
  reg [4:0]        pend_idx_r;
  reg [NSRC-1:0]   pend_hot_r;
  reg [ADDR_W-1:0] vec_addr_r;

  // Bus write side
  reg              aw_hold_r;
  reg [AXI_AW-1:0] awaddr_r;
  reg              w_hold_r;
  reg [31:0]       wdata_r;
  reg [3:0]        wstrb_r;
  reg              bvalid_r;
  reg [1:0]        bresp_r;

  // Bus read side
  reg              rvalid_r;
  reg [31:0]       rdata_r;
  reg [1:0]        rresp_r;
  reg [31:0]       rd_nxt;
  reg              rd_hit;

  wire [NSRC-1:0]  pend;
  wire             enc_any;
  wire [4:0]       enc_idx;
  wire [NSRC-1:0]  enc_hot;
  wire             window_open;
  wire             irq_block;
  wire             do_write;
  wire             wr_gic;
  wire             chg_start;
  wire             sel_write;
  wire             still_pend;
  wire             take;
  wire [ADDR_W-1:0] lookup_addr;

  // Enabled pending requests
  assign pend = irq_req & mask_r;

  rivm_prio_enc #(
    .NSRC (NSRC)
  ) u_enc (
    .pend   (pend),
    .any    (enc_any),
    .idx    (enc_idx),
    .onehot (enc_hot)
  );

  // Control register write decode
  assign do_write  = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_gic    = do_write & (word_of(awaddr_r) == `RIVM_OFS_GIC) & wstrb_r[0];
  assign chg_start = wr_gic & wdata_r[`RIVM_GIC_CHG_BIT];
  assign sel_write = wr_gic & ~wdata_r[`RIVM_GIC_CHG_BIT] & window_open;

  rivm_change_guard u_guard (
    .clk          (clk),
    .nrst         (nrst),
    .chg_start    (chg_start),
    .sel_write    (sel_write),
    .instr_retire (instr_retire),
    .window_open  (window_open),
    .irq_block    (irq_block)
  );

  // Vector select, changed only inside the window
  always @(posedge clk)
  begin
    if (!nrst)
      sel_r <= `RIVM_RST_SEL;
    else if (sel_write)
      sel_r <= wdata_r[`RIVM_GIC_SEL_BIT];
  end

  // Reset start address from boot fuse
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      reset_addr_r  <= boot_reset_fuse ? RESET_ADDR : boot_start_addr;
      reset_fetch_r <= 1'b0;
      boot_seen_r   <= 1'b0;
    end
    else
    begin
      reset_addr_r  <= boot_reset_fuse ? RESET_ADDR : boot_start_addr;
      reset_fetch_r <= ~boot_seen_r;
      boot_seen_r   <= 1'b1;
    end
  end

  // Registered arbitration
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      pend_any_r <= 1'b0;
      pend_idx_r <= 5'h00;
      pend_hot_r <= {NSRC{1'b0}};
      vec_addr_r <= VEC_BASE;
    end
    else
    begin
      pend_any_r <= enc_any;
      pend_idx_r <= enc_idx;
      pend_hot_r <= enc_hot;
      vec_addr_r <= vec_addr(enc_idx, sel_r, boot_start_addr);
    end
  end

  // Offer vector only for a live enabled request
  assign still_pend = |(pend & pend_hot_r);
  assign irq_valid  = pend_any_r & still_pend & global_irq_enable & ~irq_block;
  assign take       = irq_valid & irq_ack;
  assign irq_taken  = take ? pend_hot_r : {NSRC{1'b0}};

  assign irq_vector_addr  = vec_addr_r;
  assign irq_vector_num   = pend_idx_r + `RIVM_VEC_FIRST;
  assign reset_fetch_addr = reset_addr_r;
  assign reset_fetch      = reset_fetch_r;

  // Vector lookup for any vector number
  assign lookup_addr = (lookup_r == `RIVM_RESET_VEC) ? reset_addr_r :
                       ((lookup_r >= `RIVM_VEC_FIRST) && (lookup_r <= `RIVM_VEC_LAST)) ?
                       vec_addr(lookup_r - `RIVM_VEC_FIRST, sel_r, boot_start_addr) :
                       {ADDR_W{1'b0}};

  // Bus write channels, either order
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= {AXI_AW{1'b0}};
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RIVM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (word_of(awaddr_r) > `RIVM_OFS_TAKEN) ? `RIVM_RESP_SLVERR : `RIVM_RESP_OKAY;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Writable configuration with byte strobes
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      mask_r   <= `RIVM_RST_MASK;
      lookup_r <= 5'h00;
    end
    else if (do_write)
    begin
      if (word_of(awaddr_r) == `RIVM_OFS_MASK)
      begin
        if (wstrb_r[0])
          mask_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1])
          mask_r[15:8] <= wdata_r[15:8];
        if (wstrb_r[2])
          mask_r[NSRC-1:16] <= wdata_r[NSRC-1:16];
      end
      if ((word_of(awaddr_r) == `RIVM_OFS_LOOKUP) && wstrb_r[0])
        lookup_r <= wdata_r[4:0];
    end
  end

  // Taken counter, a take in the clearing cycle leaves it at one
  always @(posedge clk)
  begin
    if (!nrst)
      taken_cnt_r <= 16'h0000;
    else if (take)
      taken_cnt_r <= (do_write && (word_of(awaddr_r) == `RIVM_OFS_TAKEN)) ?
                     16'h0001 : taken_cnt_r + 16'h0001;
    else if (do_write && (word_of(awaddr_r) == `RIVM_OFS_TAKEN))
      taken_cnt_r <= 16'h0000;
  end

  // Read mux
  always @*
  begin
    rd_nxt = 32'h00000000;
    rd_hit = 1'b1;
    case (word_of(s_axi_araddr))
      `RIVM_OFS_GIC:
      begin
        rd_nxt[`RIVM_GIC_SEL_BIT] = sel_r;
        rd_nxt[`RIVM_GIC_CHG_BIT] = window_open;
      end
      `RIVM_OFS_MASK:
        rd_nxt[NSRC-1:0] = mask_r;
      `RIVM_OFS_PEND:
        rd_nxt[NSRC-1:0] = pend;
      `RIVM_OFS_STATUS:
      begin
        rd_nxt[`RIVM_ST_WIN_BIT]   = window_open;
        rd_nxt[`RIVM_ST_BLOCK_BIT] = irq_block;
        rd_nxt[`RIVM_ST_VALID_BIT] = irq_valid;
        rd_nxt[`RIVM_ST_SEL_BIT]   = sel_r;
        rd_nxt[`RIVM_ST_NUM_LSB +: 5] = pend_any_r ? irq_vector_num : 5'h00;
        rd_nxt[`RIVM_ST_FUSE_BIT]  = boot_reset_fuse;
      end
      `RIVM_OFS_RESET:
        rd_nxt[ADDR_W-1:0] = reset_addr_r;
      `RIVM_OFS_LOOKUP:
      begin
        rd_nxt[ADDR_W-1:0] = lookup_addr;
        rd_nxt[`RIVM_LK_NUM_LSB +: 5] = lookup_r;
      end
      `RIVM_OFS_TAKEN:
        rd_nxt[15:0] = taken_cnt_r;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Bus read channels
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `RIVM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_nxt;
      rresp_r  <= rd_hit ? `RIVM_RESP_OKAY : `RIVM_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

endmodule // rivm_vector_map

/* File: sim/rivm_vector_map_sva.sv */
`timescale 1ns/1ps
module rivm_vector_map_sva (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  // Fetch side
  input wire        boot_reset_fuse,
  input wire [13:0] boot_start_addr,
  input wire [19:0] irq_taken,
  input wire        global_irq_enable,
  input wire        irq_ack,
  input wire        irq_valid,
  input wire [13:0] irq_vector_addr,
  input wire [4:0]  irq_vector_num,
  input wire [13:0] reset_fetch_addr,
  input wire        reset_fetch,
  // Bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [13:0] ofs = {8'h00, irq_vector_num, 1'b0} - 14'h0002;
  property p_rst_go;
    $rose(nrst) |-> ##[0:2] reset_fetch;
  endproperty
  a_rst_go: assert property (p_rst_go) else $error("no reset fetch");
  property p_rst_addr;
    reset_fetch |-> reset_fetch_addr == (boot_reset_fuse ? 14'h0000 : boot_start_addr);
  endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("bad reset address");
  property p_vec;
    irq_valid |-> irq_vector_num inside {[5'h02:5'h15]} &&
      (irq_vector_addr == ofs || irq_vector_addr == boot_start_addr + ofs);
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector address");
  property p_take;
    |irq_taken |-> irq_valid && irq_ack && irq_taken == (20'h00001 << (irq_vector_num - 5'h02));
  endproperty
  a_take: assert property (p_take) else $error("bad take");
  property p_gie;
    irq_valid |-> global_irq_enable;
  endproperty
  a_gie: assert property (p_gie) else $error("offer while disabled");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule // rivm_vector_map_sva

bind rivm_vector_map rivm_vector_map_sva rivm_vector_map_sva_inst (.clk(clk), .nrst(nrst),
  .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(boot_start_addr), .irq_taken(irq_taken),
  .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq_valid(irq_valid),
  .irq_vector_addr(irq_vector_addr), .irq_vector_num(irq_vector_num), .reset_fetch_addr(reset_fetch_addr),
  .reset_fetch(reset_fetch), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: sim/rivm_cpu_model.sv */
`timescale 1ns/1ps
module rivm_cpu_model (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Bench control
  input  wire [19:0] raise,
  input  wire        slow,
  // Controller side
  input  wire        irq_valid,
  input  wire [19:0] irq_taken,
  input  wire [4:0]  irq_vector_num,
  input  wire [13:0] irq_vector_addr,
  output reg  [19:0] irq_req,
  output reg         irq_ack,
  // Observation
  output reg         took,
  output reg  [4:0]  took_num,
  output reg  [13:0] took_addr
);
  reg [2:0] gap_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      irq_req  <= 20'h00000;
      irq_ack  <= 1'b0;
      took     <= 1'b0;
      took_num <= 5'h00;
      took_addr <= 14'h0000;
      gap_r    <= 3'h7;
    end
    else
    begin
      irq_req  <= (irq_req | raise) & ~irq_taken;
      took     <= irq_valid & irq_ack;
      took_num <= (irq_valid & irq_ack) ? irq_vector_num : took_num;
      took_addr <= (irq_valid & irq_ack) ? irq_vector_addr : took_addr;
      gap_r    <= (irq_valid & irq_ack) ? 3'h0 : gap_r + {2'h0, gap_r != 3'h7};
      irq_ack  <= irq_valid & ~irq_ack & (gap_r >= (slow ? 3'h6 : 3'h3));
    end
  end
endmodule // rivm_cpu_model

/* File: sim/rivm_vector_map_tb_top.sv */
`timescale 1ns/1ps
module rivm_vector_map_tb_top;
  logic        clk, nrst, fuse, gie, retire, slow, ack, vld, rf, took;
  logic [13:0] boot, vaddr, rfa, taddr;
  logic [19:0] req, taken, raise, set;
  logic [4:0]  vnum, tnum;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          err_total, samples_checked, nt, i, k;

  rivm_vector_map rivm_vector_map_inst (.clk(clk), .nrst(nrst), .boot_reset_fuse(fuse), .boot_start_addr(boot),
    .irq_req(req), .irq_taken(taken), .global_irq_enable(gie), .instr_retire(retire), .irq_ack(ack),
    .irq_valid(vld), .irq_vector_addr(vaddr), .irq_vector_num(vnum), .reset_fetch_addr(rfa), .reset_fetch(rf),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rivm_cpu_model rivm_cpu_model_inst (.clk(clk), .nrst(nrst), .raise(raise), .slow(slow), .irq_valid(vld),
    .irq_taken(taken), .irq_vector_num(vnum), .irq_vector_addr(vaddr), .irq_req(req), .irq_ack(ack),
    .took(took), .took_num(tnum), .took_addr(taddr));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) retire <= nrst & ~retire;

  task automatic close_out(input bit hang);
    if (hang) err_total++;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  // One bus transfer, read data left in q, response in r
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar;
    int n;
    aw = we;
    w = we;
    ar = !we;
    n = 0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    arvalid <= !we;
    while ((aw | w | ar | !(we ? bvalid : rvalid)) && n < 50)
    begin
      @(posedge clk);
      n++;
      if (aw && awready) awvalid <= 1'b0;
      if (w && wready) wvalid <= 1'b0;
      if (ar && arready) arvalid <= 1'b0;
      aw = aw && !awready;
      w = w && !wready;
      ar = ar && !arready;
    end
    if (n >= 50) close_out(1'b1);
    r = bresp;
    if (!we)
    begin
      rready <= 1'b1;
      @(posedge clk);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask

  function automatic logic [31:0] vexp(input int n, input logic sel);
    if (n == 1) return {18'h00000, fuse ? 14'h0000 : boot};
    if (n < 2 || n > 21) return 32'h00000000;
    return {18'h00000, (sel ? boot : 14'h0000) + 14'(2 * n - 2)};
  endfunction

  task automatic sweep(input logic sel);
    for (int n = 0; n < 23; n++)
    begin
      bus(1'b1, 8'h14, n);
      bus(1'b0, 8'h14, 0);
      chk("lookup", vexp(n, sel), {18'h00000, q[13:0]});
    end
  endtask

  task automatic wait_take(input logic [4:0] n);
    int c;
    c = 0;
    while (!took && c < 100)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 100) close_out(1'b1);
    chk("vec_num", n, tnum);
    chk("vec_addr", vexp(n, 1'b1), {18'h00000, taddr});
    nt++;
    @(posedge clk);
  endtask

  initial
  begin
    {err_total, samples_checked, nt, nrst, gie, slow, raise} = '0;
    {awvalid, wvalid, arvalid, rready, awaddr, araddr, wdata} = '0;
    fuse = 1'b1;
    boot = 14'h3800;
    bready = 1'b1;
    k = $urandom(32'h1399BD06);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rst_addr", 0, rfa);
    bus(1'b0, 8'h04, 0);
    chk("mask_rst", 0, q);
    bus(1'b0, 8'h1C, 0);
    chk("bad_resp", 2, r);
    chk("bad_data", 0, q);
    bus(1'b1, 8'h1C, 0);
    chk("bad_wresp", 2, r);
    sweep(1'b0);
    $display("test lookup done");
    bus(1'b1, 8'h00, 1);
    bus(1'b0, 8'h0C, 0);
    chk("blocked", 3, q[1:0]);
    repeat (8) @(posedge clk);
    bus(1'b0, 8'h0C, 0);
    chk("unblocked", 0, q[1:0]);
    bus(1'b1, 8'h00, 2);
    bus(1'b0, 8'h00, 0);
    chk("late_sel", 0, q[1]);
    bus(1'b1, 8'h00, 1);
    bus(1'b1, 8'h00, 2);
    bus(1'b0, 8'h00, 0);
    chk("sel", 1, q[1]);
    sweep(1'b1);
    $display("test select done");
    bus(1'b1, 8'h04, 32'h000FFFFF);
    raise <= 20'h00001;
    @(posedge clk);
    raise <= 20'h00000;
    repeat (10) @(posedge clk);
    chk("held", 1, req[0]);
    gie <= 1'b1;
    wait_take(5'h02);
    for (i = 0; i < 8; i++)
    begin
      set = (i == 0) ? 20'hFFFFF : 20'($urandom);
      slow <= i[0];
      raise <= set;
      @(posedge clk);
      raise <= 20'h00000;
      for (k = 0; k < 20; k++)
        if (set[k]) wait_take(5'(k + 2));
    end
    bus(1'b0, 8'h18, 0);
    chk("taken_cnt", nt, q);
    $display("test priority done");
    nrst <= 1'b0;
    fuse <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("boot_rst", 14'h3800, rfa);
    sweep(1'b0);
    $display("test boot done");
    close_out(1'b0);
  end
endmodule // rivm_vector_map_tb_top
